// ### logic/serial_port_pkg.sv
// shared constants and types of the serial port control unit
package serial_port_pkg;
	// register indices; byte address is four times the index
	localparam logic [29:0] IDX_DATA = 30'h00ffe260;
	localparam logic [29:0] IDX_CTL = 30'h00ffe262;
	localparam logic [29:0] IDX_STAT = 30'h00ffe264;
	localparam logic [29:0] IDX_BRG = 30'h00ffe266;

	// control register fields
	localparam int CTL_DATA_IRQ_ENABLE = 7;
	localparam int CTL_EN_HI = 6;
	localparam int CTL_RATE_GEN_CONTROL = 5;
	localparam int CTL_PHASE = 4;
	localparam int CTL_CLOCK_POLARITY_SEL = 3;
	localparam int CTL_WOR = 2;
	localparam int CTL_MASTER_MODE_ENABLE = 1;
	localparam int CTL_EN_LO = 0;
	localparam logic [7:0] CTL_RESET = 8'h00;

	// enable and direction codes {hi, lo}
	localparam logic [1:0] EN_OFF = 2'h0;
	localparam logic [1:0] EN_RX_ONLY = 2'h1;
	localparam logic [1:0] EN_TX_ONLY = 2'h2;
	localparam logic [1:0] EN_BOTH = 2'h3;

	// status register fields
	localparam int ST_TX_DATA_EMPTY = 7;
	localparam int ST_TX_UNDERRUN_FLAG = 6;
	localparam int ST_COL = 5;
	localparam int ST_ABT = 4;
	localparam int ST_RX_OVERRUN_FLAG = 3;
	localparam int ST_RX_DATA_FULL = 2;
	localparam int ST_TFST = 1;
	localparam int ST_SLAS = 0;

	localparam logic [15:0] BRG_RESET = 16'h0000;
	localparam logic [3:0] BITS_PER_CHAR = 4'h8;
	localparam logic [7:0] IDLE_ONES = 8'hff;

	// transfer sequencer states, one-hot
	typedef enum logic [1:0] {
		XS_IDLE = 2'b01,
		XS_SHIFT = 2'b10
	} xfer_state_t;

	// the four serial pins travel together
	typedef struct packed {
		logic sck;
		logic ss;
		logic miso;
		logic mosi;
	} spi_pins_t;

	// error flags cleared by writing one
	typedef struct packed {
		logic tx_underrun_flag;
		logic col;
		logic slave_abort_flag;
		logic rx_overrun_flag;
	} err_flags_t;
endpackage

// ### logic/serial_port_control_unit.sv
// serial port control unit: apb registers, rate generator and shift engine
// What this block does
// - data irqs masked, errors still interrupt
// - data irq enable adds empty/full interrupts
// - enable field 00 disables; generator timer usable
// - receive only: empty flag, no tx requests
// - receive-only slave shifts out all ones
// - transmit only: full flag, no rx requests
// - both directions: both flags and requests
// - disabled, control 0: timer off, reload read
// - disabled, control 1: timer runs, counter read
// - enabled: reload or counter read; master clocks
// - slave: idle or serial clock time-out
// - polarity bit selects serial clock idle level
// - wired-or bit makes all pins open-drain
// - slave: out on miso, in mosi, sck input
// - master: out on mosi, in miso, sck output
// - data writes ignored while empty flag clear
// - disabling returns status to reset values
`timescale 1ns/1ps
module serial_port_control_unit
	import serial_port_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire serial_port_pkg::spi_pins_t pinIn,
	output serial_port_pkg::spi_pins_t pinOut,
	output serial_port_pkg::spi_pins_t pinOeN,
	output logic irqReq,
	output logic txDmaReq,
	output logic rxDmaReq
);
	import serial_port_pkg::*;

	typedef struct packed {
		logic [7:0] ctl;
		logic [15:0] brgReload;
		logic [15:0] brgCnt;
		logic [7:0] txData;
		logic txFull;
		logic [7:0] rxData;
		logic rx_data_full;
		err_flags_t err;
		xfer_state_t xs;
		logic [7:0] txSh;
		logic [7:0] rxSh;
		logic outBit;
		logic [3:0] bitCnt;
		logic sckPh;
		spi_pins_t sync1;
		spi_pins_t sync2;
		logic sckPrev;
		spi_pins_t pinOut;
		spi_pins_t pinOeN;
		logic irq;
		logic txDma;
		logic rxDma;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} state_t;

	localparam state_t STATE_RESET = '{
		ctl: CTL_RESET, brgReload: BRG_RESET, brgCnt: BRG_RESET,
		txData: 8'h00, txFull: 1'b0, rxData: 8'h00, rx_data_full: 1'b0,
		err: '0, xs: XS_IDLE, txSh: 8'h00, rxSh: 8'h00, outBit: 1'b1,
		bitCnt: 4'h0, sckPh: 1'b0, sync1: '1, sync2: '1, sckPrev: 1'b0,
		pinOut: '0, pinOeN: '1, irq: 1'b0, txDma: 1'b0, rxDma: 1'b0,
		prdata: 32'h00000000, pready: 1'b0, pslverr: 1'b0
	};

	state_t s;
	state_t n;

	logic [1:0] enField;
	logic enabled;
	logic master;
	logic txEn;
	logic rxEn;
	logic pol;
	logic phase;
	logic busy;
	logic tx_data_empty;
	logic [7:0] statVal;
	logic [15:0] brgView;
	logic brgRun;
	logic tick;
	logic timeout;
	logic lead;
	logic trail;
	logic sckLvl;
	logic din;
	logic ssAct;
	logic [7:0] rxNext;
	logic setup;
	logic access;
	logic hitData;
	logic hitCtl;
	logic hitStat;
	logic hitBrg;
	err_flags_t errSet;
	err_flags_t errClr;
	logic rdrfSet;
	logic rdrfClr;
	spi_pins_t drive;
	spi_pins_t val;
	logic [7:0] loadVal;
	logic startXfer;

	// decoded control fields
	assign enField = {s.ctl[CTL_EN_HI], s.ctl[CTL_EN_LO]};
	assign enabled = enField != EN_OFF;
	assign master = s.ctl[CTL_MASTER_MODE_ENABLE];
	assign txEn = enField[1];
	assign rxEn = enField[0];
	assign pol = s.ctl[CTL_CLOCK_POLARITY_SEL];
	assign phase = s.ctl[CTL_PHASE];
	assign busy = s.xs == XS_SHIFT;
	assign tx_data_empty = enabled & ~s.txFull;
	assign statVal = {tx_data_empty, s.err.tx_underrun_flag, s.err.col, s.err.slave_abort_flag, s.err.rx_overrun_flag, s.rx_data_full, busy,
		(enabled & ~master) ? s.sync2.ss : 1'b1};
	assign brgView = s.ctl[CTL_RATE_GEN_CONTROL] ? s.brgCnt : s.brgReload;

	// apb decode on the word index
	assign setup = psel & ~penable & ~s.pready;
	assign access = psel & penable & s.pready;
	assign hitData = paddr[31:2] == IDX_DATA;
	assign hitCtl = paddr[31:2] == IDX_CTL;
	assign hitStat = paddr[31:2] == IDX_STAT;
	assign hitBrg = paddr[31:2] == IDX_BRG; // whole word read keeps halves in step

	// generator runs: master clocking, standalone timer, slave time-out
	assign brgRun = (enabled & master & busy)
		| (~enabled & s.ctl[CTL_RATE_GEN_CONTROL])
		| (enabled & ~master & s.ctl[CTL_RATE_GEN_CONTROL] & busy);
	assign tick = brgRun & (s.brgCnt == 16'h0001);
	assign timeout = tick & ~enabled; // timer time-out

	// serial clock edges, synchronised pins only
	assign sckLvl = s.sync2.sck ^ pol;
	assign ssAct = ~s.sync2.ss;
	assign din = master ? s.sync2.miso : s.sync2.mosi;
	always_comb begin
		lead = 1'b0;
		trail = 1'b0;
		if (master) begin
			lead = tick & ~s.sckPh;
			trail = tick & s.sckPh;
		end else if (busy) begin
			lead = sckLvl & ~s.sckPrev;
			trail = ~sckLvl & s.sckPrev;
		end
	end

	// next state
	always_comb begin
		n = s;
		errSet = '0;
		errClr = '0;
		rdrfSet = 1'b0;
		rdrfClr = 1'b0;
		rxNext = s.rxSh;
		loadVal = IDLE_ONES;
		startXfer = 1'b0;
		drive = '0;
		val = '0;
		n.sync1 = pinIn;
		n.sync2 = s.sync1;
		n.sckPrev = sckLvl;

		// apb slave: answer one cycle after setup
		n.pready = setup;
		if (setup) begin
			n.pslverr = ~(hitData | hitCtl | hitStat | hitBrg);
			n.prdata = 32'h00000000;
			if (!pwrite) begin
				if (hitData) n.prdata = {24'h000000, s.rxData};
				if (hitCtl) n.prdata = {24'h000000, s.ctl};
				if (hitStat) n.prdata = {24'h000000, statVal};
				if (hitBrg) n.prdata = {16'h0000, brgView};
			end
		end
		if (access & pwrite) begin
			if (hitCtl & pstrb[0]) n.ctl = pwdata[7:0];
			if (hitBrg & pstrb[0]) n.brgReload[7:0] = pwdata[7:0];
			if (hitBrg & pstrb[1]) n.brgReload[15:8] = pwdata[15:8];
			if (hitStat & pstrb[0]) errClr = pwdata[ST_TX_UNDERRUN_FLAG:ST_RX_OVERRUN_FLAG];
			if (hitData & pstrb[0] & tx_data_empty) begin
				n.txData = pwdata[7:0];
				n.txFull = 1'b1;
			end
		end
		if (access & ~pwrite & hitData) rdrfClr = 1'b1;

		// rate generator counter
		if (!brgRun) n.brgCnt = s.brgReload;
		else if (tick) n.brgCnt = s.brgReload;
		else n.brgCnt = s.brgCnt - 16'h0001;

		// transfer sequencer
		unique case (s.xs)
			XS_IDLE: begin
				if (enabled & master & s.txFull) begin
					startXfer = 1'b1;
					loadVal = s.txData;
					n.txFull = 1'b0;
				end else if (enabled & ~master & ssAct) begin
					startXfer = 1'b1;
					if (!txEn) begin
						loadVal = IDLE_ONES;
					end else if (s.txFull) begin
						loadVal = s.txData;
						n.txFull = 1'b0;
					end else begin
						errSet.tx_underrun_flag = 1'b1;
					end
				end
				if (startXfer) begin
					n.xs = XS_SHIFT;
					n.bitCnt = BITS_PER_CHAR;
					n.sckPh = 1'b0;
					n.brgCnt = s.brgReload;
					n.outBit = phase ? 1'b1 : loadVal[7];
					n.txSh = phase ? loadVal : {loadVal[6:0], 1'b1};
				end
			end
			XS_SHIFT: begin
				if (tick & master) n.sckPh = ~s.sckPh;
				if (lead | trail) begin
					if (!master) n.brgCnt = s.brgReload;
					if (lead ^ phase) begin
						rxNext = {s.rxSh[6:0], din};
						n.rxSh = rxNext;
					end else begin
						n.outBit = s.txSh[7];
						n.txSh = {s.txSh[6:0], 1'b1};
					end
				end
				if (trail) begin
					n.bitCnt = s.bitCnt - 4'h1;
					if (s.bitCnt == 4'h1) begin
						n.xs = XS_IDLE;
						n.sckPh = 1'b0;
						n.rxData = rxNext;
						rdrfSet = 1'b1;
						if (s.rx_data_full & ~rdrfClr) errSet.rx_overrun_flag = 1'b1;
					end
				end
				if (!master & (tick | ~ssAct)) begin
					errSet.slave_abort_flag = 1'b1; // slave deselect or clock time-out
					n.xs = XS_IDLE;
				end
				if (master & ~s.sync2.ss) begin
					errSet.col = 1'b1; // another master selected us
					n.xs = XS_IDLE;
					n.sckPh = 1'b0;
				end
			end
			default: n.xs = XS_IDLE;
		endcase

		// sticky flags, set wins over clear
		n.err = (s.err & ~errClr) | errSet;
		n.rx_data_full = (s.rx_data_full & ~rdrfClr) | rdrfSet;

		// disabled port: status back to reset
		if (!enabled) begin
			n.xs = XS_IDLE;
			n.txFull = 1'b0;
			n.rx_data_full = 1'b0;
			n.err = '0;
			n.sckPh = 1'b0;
		end

		// pin roles and drive levels
		if (enabled) begin
			if (master) begin
				drive.sck = 1'b1;
				val.sck = pol ^ s.sckPh;
				drive.mosi = 1'b1;
				val.mosi = s.outBit;
			end else begin
				drive.miso = ssAct;
				val.miso = s.outBit;
			end
		end
		if (s.ctl[CTL_WOR]) begin
			n.pinOut = '0;
			n.pinOeN = ~(drive & ~val);
		end else begin
			n.pinOut = val;
			n.pinOeN = ~drive;
		end

		// interrupt and dma requests
		n.txDma = tx_data_empty & txEn;
		n.rxDma = s.rx_data_full & rxEn;
		n.irq = (|s.err) | timeout
			| (s.ctl[CTL_DATA_IRQ_ENABLE] & ((tx_data_empty & txEn) | (s.rx_data_full & rxEn)));
	end

	// state register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s <= STATE_RESET;
		end else begin
			s <= n;
		end
	end

	// outputs straight from flops
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign pinOut = s.pinOut;
	assign pinOeN = s.pinOeN;
	assign irqReq = s.irq;
	assign txDmaReq = s.txDma;
	assign rxDmaReq = s.rxDma;
endmodule

// ### sim/serial_port_control_unit_chk.sv
// port checker of the serial port control unit
`timescale 1ns/1ps
module serial_port_control_unit_chk
	import serial_port_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire serial_port_pkg::spi_pins_t pinOut,
	input wire serial_port_pkg::spi_pins_t pinOeN,
	input wire logic irqReq,
	input wire logic txDmaReq,
	input wire logic rxDmaReq
);
	logic [7:0] ctl_q;
	logic [7:0] prev_q;
	logic steady;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// mirror of the control register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctl_q <= CTL_RESET;
			prev_q <= CTL_RESET;
		end else begin
			prev_q <= ctl_q;
			if (psel && penable && pready && pwrite && paddr[31:2] == IDX_CTL) begin
				ctl_q <= pwdata[7:0];
			end
		end
	end
	assign steady = (ctl_q == prev_q);
	sequence setup;
		psel && !penable;
	endsequence
	// control settled for two cycles
	sequence calm;
		steady && $past(steady);
	endsequence
	AST_ZERO_WAIT: assert property (setup |=> pready && penable)
		else $error("late pready");
	AST_TX_DMA: assert property (calm ##0 !ctl_q[6] |-> !txDmaReq)
		else $error("tx request while tx off");
	AST_RX_DMA: assert property (calm ##0 !ctl_q[0] |-> !rxDmaReq)
		else $error("rx request while rx off");
	AST_DATA_IRQ: assert property (calm ##0 ctl_q[7] && txDmaReq |-> irqReq)
		else $error("data irq missing");
	AST_OFF: assert property (calm ##0 !ctl_q[6] && !ctl_q[0] |-> pinOeN == 4'hf)
		else $error("pins driven while off");
	AST_OPEN_DRAIN: assert property (calm ##0 ctl_q[2] |-> (~{pinOeN} & {pinOut}) == 4'h0)
		else $error("pin driven high");
	AST_SLAVE_PINS: assert property (calm ##0 !ctl_q[1] |-> pinOeN.sck && pinOeN.mosi)
		else $error("slave drives sck or mosi");
	AST_MASTER_PINS: assert property (calm ##0 ctl_q[1] && (ctl_q[6] || ctl_q[0]) && !ctl_q[2]
		|-> !pinOeN.sck && pinOeN.miso)
		else $error("master pin roles wrong");
endmodule
bind serial_port_control_unit serial_port_control_unit_chk chk (.clk_sys, .rst, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .pinOut, .pinOeN, .irqReq, .txDmaReq, .rxDmaReq);

// ### sim/spi_far_slave.sv
// far-end spi slave model, msb first
`timescale 1ns/1ps
module spi_far_slave (
	input wire logic sck,
	input wire logic mosi,
	input wire logic load,
	input wire logic [7:0] txByte,
	output logic miso,
	output logic [7:0] rxByte
);
	logic [7:0] shift_q;
	assign miso = shift_q[7];
	// sample master data on the leading edge
	always @(posedge sck) begin
		rxByte <= {rxByte[6:0], mosi};
	end
	// next bit on the trailing edge, or a new byte
	always @(negedge sck or posedge load) begin
		if (load) begin
			shift_q <= txByte;
		end else begin
			shift_q <= {shift_q[6:0], 1'b1};
		end
	end
endmodule

// ### sim/serial_port_control_unit_tb.sv
// self-checking bench of the serial port control unit
`timescale 1ns/1ps
module serial_port_control_unit_tb;
	import serial_port_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, irqReq, txDmaReq, rxDmaReq, farMiso, errSeen;
	logic farLoad = 1'b0;
	logic ssN = 1'b1;
	logic [7:0] farTx = 8'h0;
	logic [7:0] farRx;
	spi_pins_t pinIn, pinOut, pinOeN;
	logic [31:0] rd, r1, seed;
	int failures, checkCount, n;
	always #5 clk_sys = ~clk_sys;
	// pin levels: pull-ups where nobody drives, slave select from the bench
	assign pinIn = {pinOeN.sck ? 1'b1 : pinOut.sck, ssN, pinOeN.miso ? farMiso : pinOut.miso,
		pinOeN.mosi ? 1'b1 : pinOut.mosi};
	serial_port_control_unit uut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb(4'hf), .prdata, .pready, .pslverr, .pinIn, .pinOut, .pinOeN, .irqReq,
		.txDmaReq, .rxDmaReq);
	spi_far_slave far (.sck(pinIn.sck), .mosi(pinIn.mosi), .load(farLoad), .txByte(farTx),
		.miso(farMiso), .rxByte(farRx));
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [31:0] ctlw(input logic [1:0] en, input logic [7:0] f);
		logic [31:0] c;
		c = {24'h0, f};
		c[CTL_EN_HI] = en[1];
		c[CTL_EN_LO] = en[0];
		return c;
	endfunction
	// status of an idle slave: empty flag only when enabled
	function automatic logic [31:0] expStat(input logic [1:0] en);
		return {24'h0, en != EN_OFF, 6'h0, 1'b1};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one apb transfer; waits for pready, only the watchdog ends a hang
	task automatic apb(input logic w, input logic [29:0] idx, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) begin
			@(posedge clk_sys);
		end
		rd = prdata;
		errSeen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checkCount, failures);
		if (failures == 0 && checkCount > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		#500000;
		failures++;
		give_verdict;
	end
	initial begin
		seed = 32'h9a44;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		apb(1'b0, IDX_CTL, 32'h0);
		chk(rd, {24'h0, CTL_RESET});
		apb(1'b0, IDX_STAT, 32'h0);
		chk(rd, expStat(EN_OFF));
		apb(1'b1, IDX_CTL + 30'h10, 32'hff);
		chk({31'h0, errSeen}, 32'h1);
		$display("test 1 done");
		// every mode with data irqs masked and enabled
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, IDX_CTL, ctlw(i[1:0], {i[2], 7'h0}));
			repeat (3) @(posedge clk_sys);
			chk({irqReq, txDmaReq, rxDmaReq}, {i[2] & i[1], i[1], 1'b0});
			apb(1'b0, IDX_STAT, 32'h0);
			chk(rd, expStat(i[1:0]));
		end
		$display("test 2 done");
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			apb(1'b1, IDX_BRG, {16'h0, seed[15:0]});
			apb(1'b1, IDX_CTL, ctlw(i[1:0], 8'h0));
			apb(1'b0, IDX_BRG, 32'h0);
			chk(rd, {16'h0, seed[15:0]});
		end
		apb(1'b1, IDX_BRG, 32'h8000);
		apb(1'b1, IDX_CTL, ctlw(EN_OFF, 8'h20));
		apb(1'b0, IDX_BRG, 32'h0); // whole-word read
		r1 = rd;
		apb(1'b0, IDX_BRG, 32'h0);
		chk({31'h0, rd !== r1}, 32'h1);
		// standalone timer: one irq pulse per reload cycles
		apb(1'b1, IDX_CTL, 32'h0);
		apb(1'b1, IDX_BRG, 32'h10);
		apb(1'b1, IDX_CTL, ctlw(EN_OFF, 8'h20));
		n = 0;
		while (irqReq !== 1'b1 && n < 100) begin
			n++;
			@(posedge clk_sys);
		end
		@(posedge clk_sys);
		n = 1;
		while (irqReq !== 1'b1 && n < 100) begin
			n++;
			@(posedge clk_sys);
		end
		chk(n, 32'h10);
		$display("test 3 done");
		// idle clock level and pin roles, push-pull and open-drain
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, IDX_CTL, ctlw(EN_BOTH, {4'h0, i[0], i[1], 2'b10}));
			repeat (3) @(posedge clk_sys);
			chk({pinIn.sck, pinOeN.miso}, {i[0], 1'b1});
		end
		apb(1'b1, IDX_CTL, ctlw(EN_BOTH, 8'h0));
		repeat (3) @(posedge clk_sys);
		chk({pinOeN.sck, pinOeN.mosi}, 2'b11);
		$display("test 4 done");
		// master bytes; a data write while off must not start one
		apb(1'b1, IDX_CTL, 32'h0);
		apb(1'b1, IDX_DATA, 32'h5a);
		apb(1'b1, IDX_BRG, 32'h4);
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, IDX_CTL, ctlw(i ? EN_RX_ONLY : EN_BOTH, 8'h02));
			seed = xs(seed);
			farTx <= seed[7:0];
			farLoad <= 1'b1;
			repeat (100) @(posedge clk_sys);
			farLoad <= 1'b0;
			chk({31'h0, rxDmaReq}, 32'h0);
			apb(1'b1, IDX_DATA, {24'h0, seed[15:8]});
			n = 0;
			while (rxDmaReq !== 1'b1 && n < 400) begin
				n++;
				@(posedge clk_sys);
			end
			chk({rxDmaReq, txDmaReq}, {1'b1, i == 0});
			apb(1'b0, IDX_DATA, 32'h0);
			chk(rd, {24'h0, farTx});
			if (i == 0) chk({24'h0, farRx}, {24'h0, seed[15:8]});
		end
		// queued byte holds; a second write while full is dropped
		apb(1'b1, IDX_CTL, ctlw(EN_BOTH, 8'h0));
		seed = xs(seed);
		farTx <= seed[7:0];
		farLoad <= 1'b1;
		apb(1'b1, IDX_DATA, {24'h0, seed[15:8]});
		apb(1'b1, IDX_DATA, {24'h0, ~seed[15:8]});
		apb(1'b0, IDX_STAT, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, IDX_CTL, ctlw(EN_BOTH, 8'h02));
		@(posedge clk_sys);
		farLoad <= 1'b0;
		n = 0;
		while (rxDmaReq !== 1'b1 && n < 400) begin
			n++;
			@(posedge clk_sys);
		end
		chk({24'h0, farRx}, {24'h0, seed[15:8]});
		apb(1'b0, IDX_DATA, 32'h0);
		chk(rd, {24'h0, farTx});
		$display("test 5 done");
		// slave selects: ones out, errors interrupt with data irqs masked
		apb(1'b1, IDX_CTL, ctlw(EN_RX_ONLY, 8'h0));
		ssN <= 1'b0;
		repeat (6) @(posedge clk_sys);
		chk({30'h0, pinOeN.miso, pinOut.miso}, 32'h1);
		ssN <= 1'b1;
		repeat (6) @(posedge clk_sys);
		chk({31'h0, irqReq}, 32'h1);
		apb(1'b0, IDX_STAT, 32'h0);
		chk(rd, 32'h91);
		apb(1'b1, IDX_STAT, 32'h78);
		apb(1'b0, IDX_STAT, 32'h0);
		chk(rd, 32'h81);
		chk({31'h0, irqReq}, 32'h0);
		apb(1'b1, IDX_CTL, ctlw(EN_BOTH, 8'h0));
		ssN <= 1'b0;
		repeat (6) @(posedge clk_sys);
		ssN <= 1'b1;
		repeat (6) @(posedge clk_sys);
		chk({31'h0, irqReq}, 32'h1);
		apb(1'b0, IDX_STAT, 32'h0);
		chk(rd, 32'hd1);
		apb(1'b1, IDX_CTL, 32'h0);
		apb(1'b0, IDX_STAT, 32'h0);
		chk(rd, expStat(EN_OFF));
		$display("test 6 done");
		give_verdict;
	end
endmodule
